// *** rtl/urs_pkg.sv ***
/*
  Shared constants and types for the ultrasonic ranging sequencer:
  link timing, baseband dividers, mode encoding and the controller's
  register map. Assumes a single 20 MHz pclk domain on both ends.
*/
package urs_pkg;
  // clock and event-line timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int EVT_PULSE_NS  = 2000;                                   // inside the 1-10 us window
  localparam int EVT_PULSE_CYC = EVT_PULSE_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int CAL_PULSE_MS  = 100;
  localparam int CAL_PULSE_CYC = CAL_PULSE_MS * (CLK_HZ / 1000);

  // baseband sampling and transmit burst, in transducer cycles
  localparam int FS_DIV_NORMAL   = 8;
  localparam int FS_DIV_SHORT    = 2;
  localparam int TX_TICKS_NORMAL = 32;
  localparam int TX_TICKS_SHORT  = 8;

  // sensor housekeeping
  localparam int          RTC_DIV     = 610;                             // pclk cycles per rtc tick
  localparam int          SELF_CHECK_WIN = 1000;                         // pclk cycles of frequency count
  localparam logic [15:0] ECHO_THRESH = 16'h0100;

  // operating modes, in the order the mode field encodes them
  typedef enum logic [1:0] {URS_FREE_RUN, URS_TRIG_TXRX, URS_TRIG_RXONLY} urs_mode_e;

  // controller register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_PERIOD = 8'h08;
  localparam logic [7:0] REG_TICK   = 8'h0C;
  localparam logic [7:0] REG_MAXR   = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RANGE  = 8'h18;
  localparam logic [7:0] REG_CALCNT = 8'h1C;
  localparam logic [7:0] REG_FREQ   = 8'h20;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SHORT    = 2;
  localparam int CTRL_STREJ    = 3;
  localparam int CTRL_CAL      = 4;
  localparam int CMD_TRIG      = 0;
  localparam int CMD_CAL       = 1;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE     = 1;
  localparam int STAT_CALDONE  = 2;

  // reset values
  localparam logic [4:0]  CTRL_RST   = 5'h01;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] TICK_RST   = 16'h0800;
  localparam logic [15:0] MAXR_RST   = 16'h0040;
endpackage : urs_pkg

// *** rtl/urs_link_if.sv ***
/*
  Link between controller and sensor: the shared event line, driven
  high by either end and pulled low otherwise, plus a parallel stand-in
  for the configuration serial bus. Assumes both ends run on pclk.
*/
`timescale 1ns/10ps
interface urs_link_if;
  import urs_pkg::*;
  logic        dev_evt_out;
  logic        dev_evt_oe;
  logic        host_evt_out;
  logic        host_evt_oe;
  logic        evt;
  urs_mode_e   cfg_mode;
  logic        cfg_short;
  logic        cfg_strej;
  logic        cfg_cal_arm;
  logic [15:0] cfg_period;
  logic [15:0] cfg_tick;
  logic [15:0] cfg_maxr;
  logic [15:0] res_range;
  logic [31:0] res_cal;
  logic [31:0] res_freq;

  // high-side drivers only; the internal pull-down gives low when idle
  assign evt = (dev_evt_oe & dev_evt_out) | (host_evt_oe & host_evt_out);

  modport dev (input evt, cfg_mode, cfg_short, cfg_strej, cfg_cal_arm, cfg_period, cfg_tick,
               cfg_maxr, output dev_evt_out, dev_evt_oe, res_range, res_cal, res_freq);
  modport host (input evt, res_range, res_cal, res_freq, output host_evt_out, host_evt_oe,
                cfg_mode, cfg_short, cfg_strej, cfg_cal_arm, cfg_period, cfg_tick, cfg_maxr);
endinterface : urs_link_if

// *** rtl/urs_sensor.sv ***
/*
  Sensor end of the ranging link: power-on frequency check, free-running
  rtc timer, triggered start, transmit burst, echo listen and completion
  pulse, and rtc calibration against a host pulse.
  Assumes op_tick is one pclk pulse per transducer cycle and echo_level
  is the demodulated baseband magnitude, both synchronous to pclk.
*/
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module urs_sensor
  import urs_pkg::*;
#(
  parameter int          TX_NORMAL = TX_TICKS_NORMAL,
  parameter int          TX_SHORT  = TX_TICKS_SHORT,
  parameter int          RTC_CYC   = RTC_DIV,
  parameter int          CHECK_CYC = SELF_CHECK_WIN,
  parameter logic [15:0] THRESH    = ECHO_THRESH
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  urs_link_if.dev          link,
  input  wire logic        op_tick,
  input  wire logic [15:0] echo_level,
  output logic             tx_drive,
  output logic             meas_busy
);
  typedef enum logic [2:0] {S_SELF_CHECK, S_IDLE, S_TX, S_LISTEN, S_WREL, S_NOTE, S_CAL} urs_sst_e;

  urs_sst_e    st, next_st;
  logic [31:0] cnt, next_cnt;
  logic [3:0]  div, next_div;
  logic [15:0] sidx, next_sidx;
  logic [15:0] prev, next_prev;
  logic        hit, next_hit;
  logic [15:0] rng, next_rng;
  logic [15:0] res_range, next_res_range;
  logic [31:0] res_cal, next_res_cal;
  logic [31:0] res_freq, next_res_freq;
  logic        evt_q, next_evt_q;
  logic        tx_q, next_tx_q;
  logic        busy_q, next_busy_q;
  logic [15:0] rtc_pre, next_rtc_pre;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic [15:0] per_cnt, next_per_cnt;
  logic        wake, next_wake;
  logic        rtc_tick, rise, fall, free, consume;
  logic [3:0]  fs_last;
  logic [15:0] mag;
  assign rtc_tick = (rtc_pre == 16'(RTC_CYC - 1));
  assign rise     = link.evt & ~evt_q;
  assign fall     = ~link.evt & evt_q;
  assign free     = (link.cfg_mode == URS_FREE_RUN);
  assign consume  = (st == S_IDLE) & free & wake;
  assign fs_last  = link.cfg_short ? 4'(FS_DIV_SHORT - 1) : 4'(FS_DIV_NORMAL - 1);
  // difference of successive samples within one listen kills levels that do not change from sample to sample
  assign mag = ~link.cfg_strej ? echo_level :
               (echo_level >= prev) ? echo_level - prev : prev - echo_level;

  // free-run timer: rtc ticks gathered into wake intervals
  always_comb
  begin
    next_rtc_pre  = rtc_tick ? 16'h0000 : rtc_pre + 16'h0001;
    next_tick_cnt = tick_cnt;
    next_per_cnt  = per_cnt;
    next_wake     = wake & ~consume;
    if (!free)
    begin
      next_tick_cnt = 16'h0000;
      next_per_cnt  = 16'h0000;
      next_wake     = 1'b0;
    end
    else if (rtc_tick)
    begin
      if (tick_cnt + 16'h0001 >= link.cfg_tick)
      begin
        next_tick_cnt = 16'h0000;
        if (link.cfg_period != 16'h0000)                                 // zero period never wakes
        begin
          if (per_cnt + 16'h0001 >= link.cfg_period)
          begin
            next_per_cnt = 16'h0000;
            next_wake    = 1'b1;
          end
          else
            next_per_cnt = per_cnt + 16'h0001;
        end
      end
      else
        next_tick_cnt = tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rtc_pre  <= 16'h0000;
      tick_cnt <= 16'h0000;
      per_cnt  <= 16'h0000;
      wake     <= 1'b0;
    end
    else
    begin
      rtc_pre  <= next_rtc_pre;
      tick_cnt <= next_tick_cnt;
      per_cnt  <= next_per_cnt;
      wake     <= next_wake;
    end
  end

  // measurement sequencer
  always_comb
  begin
    next_st        = st;
    next_cnt       = cnt;
    next_div       = div;
    next_sidx      = sidx;
    next_prev      = prev;
    next_hit       = hit;
    next_rng       = rng;
    next_res_range = res_range;
    next_res_cal   = res_cal;
    next_res_freq  = res_freq;
    next_evt_q     = link.evt;
    case (st)
      S_SELF_CHECK:
      begin
        // counted straight into the result, so a read during the check shows a partial count
        next_cnt      = cnt + 32'h1;
        next_res_freq = res_freq + {31'h0, op_tick};
        if (cnt == 32'(CHECK_CYC - 1))
          next_st = S_IDLE;
      end
      S_IDLE:
      begin
        next_cnt  = 32'h0;
        next_div  = 4'h0;
        next_sidx = 16'h0000;
        next_prev = 16'h0000;                                            // no carry-over into the first difference
        next_hit  = 1'b0;
        next_rng  = 16'h0000;
        if (link.cfg_cal_arm && !free && rise)
          next_st = S_CAL;
        else if ((free && wake) || (!free && rise))
          next_st = (link.cfg_mode == URS_TRIG_RXONLY) ? S_LISTEN : S_TX;
      end
      S_TX:
      begin
        if (op_tick)
        begin
          next_cnt = cnt + 32'h1;
          if (cnt + 32'h1 >= (link.cfg_short ? 32'(TX_SHORT) : 32'(TX_NORMAL)))
            next_st = S_LISTEN;                                          // listen ignores cnt; release wait clears it
        end
      end
      S_LISTEN:
      begin
        if (op_tick)
        begin
          next_div = (div == fs_last) ? 4'h0 : div + 4'h1;
          if (div == fs_last)
          begin
            next_prev = echo_level;
            next_sidx = sidx + 16'h0001;
            if (!hit && mag >= THRESH)
            begin
              next_hit = 1'b1;
              next_rng = sidx;
            end
            if (sidx + 16'h0001 >= link.cfg_maxr)
              next_st = S_WREL;
          end
        end
      end
      S_WREL:
      begin
        // wait for the trigger to be released so the notice is a fresh edge
        if (!link.evt)
        begin
          next_res_range = rng;
          next_st        = S_NOTE;
          next_cnt       = 32'h0;
        end
      end
      S_NOTE:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt == 32'(EVT_PULSE_CYC - 1))
          next_st = S_IDLE;
      end
      S_CAL:
      begin
        if (rtc_tick)
          next_cnt = cnt + 32'h1;
        if (fall)
        begin
          next_res_cal = cnt;
          next_st      = S_IDLE;
        end
      end
      default:
        next_st = S_IDLE;
    endcase
    next_tx_q   = (next_st == S_TX);
    next_busy_q = (next_st != S_IDLE);
  end

  // rises during S_TX..S_NOTE fall into no branch above, so they are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st        <= S_SELF_CHECK;
      cnt       <= 32'h0;
      div       <= 4'h0;
      sidx      <= 16'h0000;
      prev      <= 16'h0000;
      hit       <= 1'b0;
      rng       <= 16'h0000;
      res_range <= 16'h0000;
      res_cal   <= 32'h0;
      res_freq  <= 32'h0;
      evt_q     <= 1'b0;
      tx_q      <= 1'b0;
      busy_q    <= 1'b1;
    end
    else
    begin
      st        <= next_st;
      cnt       <= next_cnt;
      div       <= next_div;
      sidx      <= next_sidx;
      prev      <= next_prev;
      hit       <= next_hit;
      rng       <= next_rng;
      res_range <= next_res_range;
      res_cal   <= next_res_cal;
      res_freq  <= next_res_freq;
      evt_q     <= next_evt_q;
      tx_q      <= next_tx_q;
      busy_q    <= next_busy_q;
    end
  end

  // the line is driven only during the short notice, never held
  assign link.dev_evt_out = (st == S_NOTE);
  assign link.dev_evt_oe  = (st == S_NOTE);
  assign link.res_range   = res_range;
  assign link.res_cal     = res_cal;
  assign link.res_freq    = res_freq;
  assign tx_drive         = tx_q;
  assign meas_busy        = busy_q;
endmodule : urs_sensor

// *** rtl/urs_host.sv ***
/*
  Controller end of the ranging link: an APB slave with its own register
  set, which triggers measurements, times the calibration pulse and
  catches completion notices. Assumes APB synchronous to pclk.
*/
`timescale 1ns/10ps
module urs_host
  import urs_pkg::*;
#(
  parameter int CAL_CYC = CAL_PULSE_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  urs_link_if.host         link
);
  typedef enum logic [1:0] {H_IDLE, H_TRIG, H_WAIT, H_CAL} urs_hst_e;

  urs_hst_e    st, next_st;
  logic [31:0] cnt, next_cnt;
  logic [4:0]  ctrl, next_ctrl;
  logic [15:0] period, next_period;
  logic [15:0] tick, next_tick;
  logic [15:0] maxr, next_maxr;
  logic [15:0] range, next_range;
  logic        done, next_done;
  logic        cal_done, next_cal_done;
  logic        evt_q, next_evt_q;
  logic [31:0] rdata, next_rdata;
  logic        wr;
  logic        note;

  function automatic logic urs_addr_ok(input logic [7:0] a);
    urs_addr_ok = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_PERIOD) || (a == REG_TICK) ||
                  (a == REG_MAXR) || (a == REG_STATUS) || (a == REG_RANGE) ||
                  (a == REG_CALCNT) || (a == REG_FREQ);
  endfunction : urs_addr_ok

  assign wr   = psel & penable & pwrite & urs_addr_ok(paddr);
  // own edges in H_TRIG and H_CAL are not notices
  assign note = link.evt & ~evt_q & ((st == H_IDLE) | (st == H_WAIT));

  // registers, status flags and pulse sequencer
  always_comb
  begin
    next_st       = st;
    next_cnt      = cnt;
    next_ctrl     = ctrl;
    next_period   = period;
    next_tick     = tick;
    next_maxr     = maxr;
    next_range    = range;
    next_done     = done;
    next_cal_done = cal_done;
    next_evt_q    = link.evt;
    next_rdata    = rdata;
    if (wr && paddr == REG_CTRL)
      next_ctrl = pwdata[4:0];
    if (wr && paddr == REG_PERIOD)
      next_period = pwdata[15:0];
    if (wr && paddr == REG_TICK)
      next_tick = pwdata[15:0];
    if (wr && paddr == REG_MAXR)
      next_maxr = pwdata[15:0];
    // write one clears; a notice in the same cycle wins
    if (wr && paddr == REG_STATUS)
    begin
      if (pwdata[STAT_DONE])
        next_done = 1'b0;
      if (pwdata[STAT_CALDONE])
        next_cal_done = 1'b0;
    end
    if (note)
    begin
      next_done  = 1'b1;
      next_range = link.res_range;
    end
    case (st)
      H_IDLE:
      begin
        next_cnt = 32'h0;
        if (wr && paddr == REG_CMD && pwdata[CMD_CAL])
          next_st = H_CAL;
        else if (wr && paddr == REG_CMD && pwdata[CMD_TRIG])
          next_st = H_TRIG;
      end
      H_TRIG:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt == 32'(EVT_PULSE_CYC - 1))
          next_st = H_WAIT;
      end
      H_WAIT:
      begin
        if (note)
          next_st = H_IDLE;
      end
      H_CAL:
      begin
        next_cnt = cnt + 32'h1;
        if (cnt == 32'(CAL_CYC - 1))
        begin
          next_st       = H_IDLE;
          next_cal_done = 1'b1;
        end
      end
      default:
        next_st = H_IDLE;
    endcase
    // read data is captured in the setup cycle so prdata comes from a flop
    if (psel && !penable)
    begin
      case (paddr)
        REG_CTRL:   next_rdata = {27'h0, ctrl};
        REG_PERIOD: next_rdata = {16'h0000, period};
        REG_TICK:   next_rdata = {16'h0000, tick};
        REG_MAXR:   next_rdata = {16'h0000, maxr};
        REG_STATUS: next_rdata = {29'h0, cal_done, done, st != H_IDLE};
        REG_RANGE:  next_rdata = {16'h0000, range};
        REG_CALCNT: next_rdata = link.res_cal;
        REG_FREQ:   next_rdata = link.res_freq;
        default:    next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st       <= H_IDLE;
      cnt      <= 32'h0;
      ctrl     <= CTRL_RST;
      period   <= PERIOD_RST;
      tick     <= TICK_RST;
      maxr     <= MAXR_RST;
      range    <= 16'h0000;
      done     <= 1'b0;
      cal_done <= 1'b0;
      evt_q    <= 1'b0;
      rdata    <= 32'h0;
    end
    else
    begin
      st       <= next_st;
      cnt      <= next_cnt;
      ctrl     <= next_ctrl;
      period   <= next_period;
      tick     <= next_tick;
      maxr     <= next_maxr;
      range    <= next_range;
      done     <= next_done;
      cal_done <= next_cal_done;
      evt_q    <= next_evt_q;
      rdata    <= next_rdata;
    end
  end

  // zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~urs_addr_ok(paddr);
  assign prdata  = rdata;

  assign link.host_evt_out = (st == H_TRIG) | (st == H_CAL);
  assign link.host_evt_oe  = (st == H_TRIG) | (st == H_CAL);
  assign link.cfg_mode     = urs_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign link.cfg_short    = ctrl[CTRL_SHORT];
  assign link.cfg_strej    = ctrl[CTRL_STREJ];
  assign link.cfg_cal_arm  = ctrl[CTRL_CAL];
  assign link.cfg_period   = period;
  assign link.cfg_tick     = tick;
  assign link.cfg_maxr     = maxr;
endmodule : urs_host

// *** test/urs_link_sva.sv ***
/*
  Event-line checker for the ranging sequencer link: drive pairing,
  pulse lengths, hand-over of the line and result timing.
  Assumes one pclk domain and an instance beside the link interface.
*/
`timescale 1ns/10ps
module urs_link_sva
  import urs_pkg::*;
#(
  parameter int CAL_CYC = CAL_PULSE_CYC
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        dev_evt_out,
  input wire logic        dev_evt_oe,
  input wire logic        host_evt_out,
  input wire logic        host_evt_oe,
  input wire logic        evt,
  input wire urs_mode_e   cfg_mode,
  input wire logic [15:0] cfg_period,
  input wire logic [31:0] res_cal
);
  localparam int PULSE = EVT_PULSE_CYC;
  logic [31:0] dcnt;
  logic [31:0] hcnt;
  logic [31:0] next_dcnt;
  logic [31:0] next_hcnt;

  // run length of each drive, judged at the cycle the drive drops
  always_comb
  begin
    next_dcnt = dev_evt_oe ? dcnt + 32'h1 : 32'h0;
    next_hcnt = host_evt_oe ? hcnt + 32'h1 : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dcnt <= 32'h0;
      hcnt <= 32'h0;
    end
    else
    begin
      dcnt <= next_dcnt;
      hcnt <= next_hcnt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // notice steps: the sensor takes the line, then lets it go
  sequence s_notice_rise;
    $rose(dev_evt_oe);
  endsequence
  sequence s_notice_end;
    $fell(dev_evt_oe);
  endsequence

  AST_DEV_PAIR: assert property (dev_evt_oe == dev_evt_out)
    else $error("sensor enable and level differ");
  AST_NOTICE_LEN: assert property (s_notice_end |-> dcnt == PULSE)
    else $error("sensor notice pulse has wrong length");
  AST_HOST_LEN: assert property ($fell(host_evt_oe) |-> hcnt == PULSE || hcnt == CAL_CYC)
    else $error("host pulse has wrong length");
  AST_HOST_HIGH: assert property (host_evt_oe |-> host_evt_out)
    else $error("host drives the line low");
  AST_AFTER_RELEASE: assert property (s_notice_rise |-> !$past(evt))
    else $error("notice started before the line was released");
  AST_NO_CONTENTION: assert property (dev_evt_oe |-> !host_evt_oe)
    else $error("both ends drive the line");
  AST_STANDBY: assert property (s_notice_rise |-> !(cfg_mode == URS_FREE_RUN && cfg_period == 16'h0000))
    else $error("notice while in standby");
  AST_CAL_STORE: assert property ($changed(res_cal) |-> !host_evt_oe)
    else $error("calibration count moved while pulse present");
endmodule : urs_link_sva

// *** test/testbench.sv ***
/*
  Self-checking bench: controller and sensor joined by the link, APB
  master tasks, random transducer ticks and a baseband ramp.
  Assumes short rtc, self-check and calibration counts set below.
*/
`timescale 1ns/10ps
module testbench
  import urs_pkg::*;
();
  localparam int RTC = 50;
  localparam int CHK_CYC = 600;
  localparam int CALC = 2000;
  localparam int CALX = CALC / RTC;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        op_tick = 1'b0;
  logic [15:0] ramp = 16'h0000;
  logic        tx_drive;
  logic        meas_busy;
  logic        oe_q = 1'b0;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors = 0;
  int          num_checks = 0;
  int          txc = 0;
  int          nc = 0;
  int          cyc = 0;
  int          fcnt = 0;
  int          n0;

  urs_link_if link ();
  urs_host #(.CAL_CYC(CALC)) i_urs_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  urs_sensor #(.RTC_CYC(RTC), .CHECK_CYC(CHK_CYC)) i_urs_sensor (.pclk(pclk), .presetn(presetn),
    .link(link), .op_tick(op_tick), .echo_level(ramp), .tx_drive(tx_drive), .meas_busy(meas_busy));
  urs_link_sva #(.CAL_CYC(CALC)) i_urs_link_sva (.pclk(pclk), .presetn(presetn),
    .dev_evt_out(link.dev_evt_out), .dev_evt_oe(link.dev_evt_oe), .host_evt_out(link.host_evt_out),
    .host_evt_oe(link.host_evt_oe), .evt(link.evt), .cfg_mode(link.cfg_mode),
    .cfg_period(link.cfg_period), .res_cal(link.res_cal));

  always #25 pclk = ~pclk;

  // random ticks; the ramp restarts with each listen so the echo index is known
  always @(posedge pclk)
  begin
    op_tick <= ($urandom % 3) == 0;
    if (tx_drive || !meas_busy)
      ramp <= 16'h0000;
    else if (op_tick)
      ramp <= ramp + 16'h0001;
    if (tx_drive && op_tick)
      txc <= txc + 1;
    if (link.dev_evt_oe && !oe_q)
      nc <= nc + 1;
    oe_q <= link.dev_evt_oe;
    if (presetn)
      cyc <= cyc + 1;
    if (presetn && cyc < CHK_CYC && op_tick)
      fcnt <= fcnt + 1;
  end

  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
      if (k > 50)
      begin
        num_errors++;
        complete_run();
      end
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask : rd

  // bounded poll of one status bit
  task wait_stat(input int b);
    int k;
    k = 0;
    rdat = 32'h0;
    while (rdat[b] !== 1'b1)
    begin
      k++;
      if (k > 4000)
      begin
        num_errors++;
        complete_run();
      end
      apb(1'b0, REG_STATUS, 32'h0);
    end
  endtask : wait_stat

  // the sensor must end its notice before the host drives the line again
  task wait_idle;
    int k;
    k = 0;
    while (meas_busy !== 1'b0)
    begin
      k++;
      if (k > 200)
      begin
        num_errors++;
        complete_run();
      end
      @(posedge pclk);
    end
  endtask : wait_idle

  // one triggered cycle; the repeated trigger lands while busy and must do nothing
  task meas(input int md, input int sh, input int sj, input int etx, input int erng);
    int t0;
    wait_idle();
    t0 = txc;
    n0 = nc;
    apb(1'b1, REG_CTRL, md | (sh << 2) | (sj << 3));
    apb(1'b1, REG_CMD, 32'h1);
    apb(1'b1, REG_CMD, 32'h1);
    check(meas_busy, 32'h1);
    rd(REG_STATUS, 32'h1);
    wait_stat(1);
    check(txc - t0, etx);
    check(nc - n0, 32'h1);
    rd(REG_RANGE, erng);
    apb(1'b1, REG_STATUS, 32'h7);
  endtask : meas

  initial
  begin
    void'($urandom(84796));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_CTRL, 32'h1);
    rd(REG_PERIOD, 32'h0);
    rd(REG_TICK, 32'h800);
    rd(REG_MAXR, 32'h40);
    repeat (CHK_CYC + 20) @(posedge pclk);
    check(meas_busy, 32'h0);
    apb(1'b0, REG_FREQ, 32'h0);
    check(rdat + 2 >= fcnt && rdat <= fcnt + 2, 32'h1);
    meas(1, 0, 0, TX_TICKS_NORMAL, 256 / FS_DIV_NORMAL);
    meas(1, 0, 1, TX_TICKS_NORMAL, 0);
    meas(2, 0, 0, 0, 256 / FS_DIV_NORMAL);
    apb(1'b1, REG_MAXR, 32'hC8);
    meas(1, 1, 0, TX_TICKS_SHORT, 256 / FS_DIV_SHORT);
    // unmapped place: refused, reads zero
    apb(1'b1, 8'h30, 32'hFFFFFFFF);
    check(rerr, 32'h1);
    rd(8'h30, 32'h0);
    check(rerr, 32'h1);
    // calibration against a host pulse of known length
    wait_idle();
    apb(1'b1, REG_CTRL, 32'h11);
    apb(1'b1, REG_CMD, 32'h2);
    wait_stat(2);
    apb(1'b0, REG_CALCNT, 32'h0);
    check(rdat + 1 >= CALX && rdat <= CALX + 1, 32'h1);
    apb(1'b1, REG_STATUS, 32'h7);
    // free run: wake every TICK * PERIOD rtc ticks, two notices
    apb(1'b1, REG_MAXR, 32'h4);
    apb(1'b1, REG_TICK, 32'h8);
    apb(1'b1, REG_CTRL, 32'h0);
    n0 = nc;
    apb(1'b1, REG_PERIOD, 32'h1);
    wait_stat(1);
    apb(1'b1, REG_STATUS, 32'h7);
    wait_stat(1);
    apb(1'b1, REG_PERIOD, 32'h0);
    apb(1'b1, REG_STATUS, 32'h7);
    check(nc - n0, 32'h2);
    repeat (2000) @(posedge pclk);
    check(nc - n0, 32'h2);
    complete_run();
  end
endmodule : testbench
